// File: src/tw_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the two-wire master
// Assumes: Word-wide register port, byte offsets
// Notes:   Definitions only
`ifndef TW_DEFINES_SVH
`define TW_DEFINES_SVH

// Register byte offsets
`define TW_OFF_CONTROL    8'h00
`define TW_OFF_MODE       8'h04
`define TW_OFF_CLOCK      8'h10
`define TW_OFF_STATUS     8'h20
`define TW_OFF_IRQ_STAT   8'h24
`define TW_OFF_IRQ_MASK   8'h28
`define TW_OFF_RX_HOLD    8'h30
`define TW_OFF_TX_HOLD    8'h34

// Control register bit positions
`define TW_CTL_START      0
`define TW_CTL_STOP       1
`define TW_CTL_MSEN       2
`define TW_CTL_MASTER_DISABLE_BIT      3

// Mode register field positions
`define TW_MODE_READ      12
`define TW_MODE_ADDR_LO   16
`define TW_MODE_ADDR_HI   22

// Reset values
`define TW_FLAGS_RST      5'h05
`define TW_CLOCK_RST      19'h0_0000
`define TW_MASK_RST       5'h00

// Largest phase count the divider can hold
`define TW_PHASE_MAX      8191
`endif

// File: src/tw_pkg.sv
// Purpose: Types shared by the two-wire master files
// Assumes: Nothing beyond SystemVerilog packages
// Notes:   Flag struct doubles as status and interrupt layout
package tw_pkg;

  // Status flags, bit 0 first from the right
  typedef struct packed {
    logic receive_overrun_flag;   // Bit 4
    logic nack_flag;              // Bit 3
    logic transmit_ready_flag;    // Bit 2
    logic receive_ready_flag;     // Bit 1
    logic transfer_complete_flag; // Bit 0
  } tw_flags_t;

  // Clock waveform fields
  typedef struct packed {
    logic [2:0] divider_exponent;    // Bits 18:16
    logic [7:0] high_period_divider; // Bits 15:8
    logic [7:0] low_period_divider;  // Bits 7:0
  } tw_clock_t;

  // Frame mode
  typedef struct packed {
    logic [6:0] dev_addr;  // Slave address
    logic       read_dir;  // High for a master read
  } tw_mode_t;

  // Bit engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_LOW,
    ST_HIGH,
    ST_STOP_LOW,
    ST_STOP_HIGH,
    ST_STOP_END
  } tw_state_t;

endpackage

// File: src/tw_sync2.sv
// Purpose: Two-flop synchroniser for the bus pins
// Assumes: Inputs asynchronous to clk_sys_i
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module tw_sync2 #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta;      // First stage
  logic [W-1:0] next_meta; // Next first stage
  logic [W-1:0] next_sync; // Next second stage

  // Idle bus level is high, so reset to ones
  always_comb begin
    next_meta = async_i;
    next_sync = meta;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta   <= '1;
      sync_o <= '1;
    end else begin
      meta   <= next_meta;
      sync_o <= next_sync;
    end
  end
endmodule
`default_nettype wire

// File: src/tw_clkdiv.sv
// Purpose: Phase counter giving one tick per serial clock phase
// Assumes: len_i is at least one
// Notes:   Count holds while run_i is low, so a freeze resumes mid-phase
`timescale 1ns/1ps
`default_nettype none
module tw_clkdiv #(
  parameter int unsigned CNT_W = 13
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic             run_i,
  input  wire logic             restart_i,
  input  wire logic [CNT_W-1:0] len_i,
  output logic                  tick_o
);
  logic [CNT_W-1:0] cnt;      // Cycles spent in this phase
  logic [CNT_W-1:0] next_cnt; // Next count

  // Tick on the last cycle of a phase; count clears for the next phase
  assign tick_o = run_i && (cnt == CNT_W'(len_i - 1'b1));

  always_comb begin
    next_cnt = cnt;
    if (restart_i) begin
      next_cnt = '0;
    end else if (tick_o) begin
      next_cnt = '0;
    end else if (run_i) begin
      next_cnt = CNT_W'(cnt + 1'b1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule
`default_nettype wire

// File: src/tw_master.sv
// Purpose: Two-wire serial master with its register port and interrupt
// Assumes: Open-drain pins resolved outside; bus pins are asynchronous
// Notes:   Keeps the known quirks of the unit on purpose
// Behaviour
// R1: Last byte after stop overwrites silently, no overrun
// R2: Host keeps scaled dividers at or below 8191
// R3: Master disable write freezes transfer at once
// R4: Master disable leaves completion, transmit-ready flags alone
// R5: Host finishes transfer, masks interrupts before disabling
// R6: Status read during nack window loses nack
// R7: Nack set with completion, status read clears it
// R8: Host waits completion interrupt, no status polling
// R9: Transmit byte end overwrites receive holding register
// R10: That overwrite raises neither receive-ready nor overrun
// R11: Host drains received byte before transmitting again
// R12: Phases count master clocks, divider scaled by exponent
//
// Our own choices: the placing of the registers and the plain strobed port.
`include "tw_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tw_master #(
  parameter int unsigned CNT_W = 13
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             irq_o,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  output logic             sda_o,
  output logic             sda_oe_o
);
  // Register state
  logic              master_en;     // Engine may run
  logic              stop_pend;     // Stop requested by software
  tw_pkg::tw_mode_t  mode;          // Address and direction
  tw_pkg::tw_clock_t clk_cfg;       // Divider settings
  logic [7:0]        tx_hold;       // Byte waiting to go out
  logic [7:0]        receive_holding_reg; // Last byte loaded
  tw_pkg::tw_flags_t flags;         // Status register content
  tw_pkg::tw_flags_t irq_stat;      // Sticky events
  tw_pkg::tw_flags_t irq_mask;      // Interrupt enables
  logic              next_master_en;
  logic              next_stop_pend;
  tw_pkg::tw_mode_t  next_mode;
  tw_pkg::tw_clock_t next_clk_cfg;
  logic [7:0]        next_tx_hold;
  logic [7:0]        next_rx_hold;
  tw_pkg::tw_flags_t next_flags;
  tw_pkg::tw_flags_t next_irq_stat;
  tw_pkg::tw_flags_t next_irq_mask;
  logic [31:0]       next_rdata;
  logic              next_irq;
  // Engine state
  tw_pkg::tw_state_t state;         // Bit engine state
  logic [8:0]        shreg;         // Outgoing bits, ack slot last
  logic [7:0]        rxsh;          // Sampled bits
  logic [3:0]        bitcnt;        // Bit within byte
  logic              is_addr;       // Address byte in flight
  logic              last;          // Read byte started after stop request
  logic              nack_pend;     // Nack seen, not yet reported
  tw_pkg::tw_state_t next_state;
  logic [8:0]        next_shreg;
  logic [7:0]        next_rxsh;
  logic [3:0]        next_bitcnt;
  logic              next_is_addr;
  logic              next_last;
  logic              next_nack_pend;
  logic              next_scl_oe;
  logic              next_sda_oe;
  // Engine events toward the registers
  logic              ev_start;      // Frame begins
  logic              ev_done;       // Stop finished
  logic              ev_take;       // Transmit byte consumed
  logic              ev_rd_byte;    // Read data byte ended
  logic              ev_wr_byte;    // Write data byte ended
  // Decoded accesses
  logic              wr_ctl;
  logic              start_wr;
  logic              master_disable_bit_wr;
  logic              rd_stat;
  logic              rd_rx;
  logic              wr_tx;
  logic              frozen;
  // Divider and pins
  logic [1:0]        pins_s;        // Synchronised scl, sda
  logic              scl_s;
  logic              sda_s;
  logic [CNT_W-1:0]  len_low;
  logic [CNT_W-1:0]  len_high;
  logic [CNT_W-1:0]  len_cur;
  logic              run;
  logic              tick;
  logic              restart;

  // Scaled phase length; truncation relies on the host keeping the limit [R2]
  function automatic logic [CNT_W-1:0] phase_len(input logic [7:0] div, input logic [2:0] expo);
    logic [14:0] scaled;
    scaled    = {7'h00, div} << expo;
    phase_len = (scaled[CNT_W-1:0] == '0) ? CNT_W'(1) : scaled[CNT_W-1:0];
  endfunction

  // Register address match, used by every write and clear-on-read decode; read data is selected by a case on addr_i
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  tw_sync2 #(.W(2)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({scl_i, sda_i}),
    .sync_o    (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Low and high phases from master clocks [R12]
  assign len_low  = phase_len(clk_cfg.low_period_divider, clk_cfg.divider_exponent);
  assign len_high = phase_len(clk_cfg.high_period_divider, clk_cfg.divider_exponent);
  assign len_cur  = (state == tw_pkg::ST_LOW || state == tw_pkg::ST_STOP_LOW) ? len_low : len_high;
  // Stall while a released clock is still held low by a slave
  assign run      = (state != tw_pkg::ST_IDLE) && !frozen && !(!scl_oe_o && !scl_s);

  tw_clkdiv #(.CNT_W(CNT_W)) u_div (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .run_i     (run),
    .restart_i (restart),
    .len_i     (len_cur),
    .tick_o    (tick)
  );

  // Access decode
  assign wr_ctl   = wr_i && hit(addr_i, `TW_OFF_CONTROL);
  assign start_wr = wr_ctl && wdata_i[`TW_CTL_START];
  assign master_disable_bit_wr = wr_ctl && wdata_i[`TW_CTL_MASTER_DISABLE_BIT];
  assign rd_stat  = rd_i && hit(addr_i, `TW_OFF_STATUS);
  assign rd_rx    = rd_i && hit(addr_i, `TW_OFF_RX_HOLD);
  assign wr_tx    = wr_i && hit(addr_i, `TW_OFF_TX_HOLD);
  // Freeze takes effect in the very cycle of the write [R3]
  assign frozen   = !master_en || master_disable_bit_wr;

  // Bit engine next state
  always_comb begin
    next_state     = state;
    next_shreg     = shreg;
    next_rxsh      = rxsh;
    next_bitcnt    = bitcnt;
    next_is_addr   = is_addr;
    next_last      = last;
    next_nack_pend = nack_pend;
    next_scl_oe    = scl_oe_o;
    next_sda_oe    = sda_oe_o;
    ev_start       = 1'b0;
    ev_done        = 1'b0;
    ev_take        = 1'b0;
    ev_rd_byte     = 1'b0;
    ev_wr_byte     = 1'b0;
    restart        = 1'b0;
    // A read in the window drops the pending nack [R6]
    if (rd_stat) begin
      next_nack_pend = 1'b0;
    end
    // Nothing moves while frozen; the frame is never finished [R3]
    if (!frozen) begin
      case (state)
        tw_pkg::ST_IDLE: begin
          if (start_wr) begin
            next_state     = tw_pkg::ST_START;
            next_sda_oe    = 1'b1;
            next_nack_pend = 1'b0;
            next_is_addr   = 1'b1;
            next_last      = 1'b0;
            next_bitcnt    = 4'h0;
            next_shreg     = {mode.dev_addr, mode.read_dir, 1'b1};
            restart        = 1'b1;
            ev_start       = 1'b1;
          end
        end
        tw_pkg::ST_START: begin
          if (tick) begin
            next_state  = tw_pkg::ST_LOW;
            next_scl_oe = 1'b1;
          end
        end
        tw_pkg::ST_LOW: begin
          // Data moves a cycle after the clock falls
          next_sda_oe = !shreg[8];
          if (tick) begin
            next_state  = tw_pkg::ST_HIGH;
            next_scl_oe = 1'b0;
          end
        end
        tw_pkg::ST_HIGH: begin
          if (tick) begin
            next_rxsh   = {rxsh[6:0], sda_s};
            next_shreg  = {shreg[7:0], 1'b1};
            next_bitcnt = 4'(bitcnt + 1'b1);
            next_scl_oe = 1'b1;
            next_state  = tw_pkg::ST_LOW;
            if (bitcnt == 4'h8) begin
              next_bitcnt  = 4'h0;
              next_is_addr = 1'b0;
              // Every data byte loads the holding register, direction ignored [R9]
              ev_rd_byte   = !is_addr && mode.read_dir;
              ev_wr_byte   = !is_addr && !mode.read_dir;
              if ((is_addr || !mode.read_dir) && sda_s) begin
                next_nack_pend = 1'b1;
                next_state     = tw_pkg::ST_STOP_LOW;
              end else if (mode.read_dir) begin
                if (!is_addr && last) begin
                  next_state = tw_pkg::ST_STOP_LOW;
                end else begin
                  // Ack every byte but the one after a stop request
                  next_shreg = {8'hFF, stop_pend};
                  next_last  = stop_pend;
                end
              end else if (!flags.transmit_ready_flag && !stop_pend) begin
                ev_take    = 1'b1;
                next_shreg = {tx_hold, 1'b1};
              end else begin
                next_state = tw_pkg::ST_STOP_LOW;
              end
            end
          end
        end
        tw_pkg::ST_STOP_LOW: begin
          next_sda_oe = 1'b1;
          if (tick) begin
            next_state  = tw_pkg::ST_STOP_HIGH;
            next_scl_oe = 1'b0;
          end
        end
        tw_pkg::ST_STOP_HIGH: begin
          if (tick) begin
            next_state  = tw_pkg::ST_STOP_END;
            next_sda_oe = 1'b0;
          end
        end
        tw_pkg::ST_STOP_END: begin
          if (tick) begin
            next_state = tw_pkg::ST_IDLE;
            ev_done    = 1'b1;
          end
        end
        default: begin
          next_state = tw_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state     <= tw_pkg::ST_IDLE;
      shreg     <= 9'h1FF;
      rxsh      <= 8'h00;
      bitcnt    <= 4'h0;
      is_addr   <= 1'b0;
      last      <= 1'b0;
      nack_pend <= 1'b0;
      scl_oe_o  <= 1'b0;
      sda_oe_o  <= 1'b0;
      scl_o     <= 1'b0;
      sda_o     <= 1'b0;
    end else begin
      state     <= next_state;
      shreg     <= next_shreg;
      rxsh      <= next_rxsh;
      bitcnt    <= next_bitcnt;
      is_addr   <= next_is_addr;
      last      <= next_last;
      nack_pend <= next_nack_pend;
      scl_oe_o  <= next_scl_oe;
      sda_oe_o  <= next_sda_oe;
      scl_o     <= 1'b0;
      sda_o     <= 1'b0;
    end
  end

  // Registers, flags and interrupt next values
  always_comb begin
    next_master_en = master_en;
    next_stop_pend = stop_pend;
    next_mode      = mode;
    next_clk_cfg   = clk_cfg;
    next_tx_hold   = tx_hold;
    next_rx_hold   = receive_holding_reg;
    next_flags     = flags;
    next_irq_stat  = irq_stat;
    next_irq_mask  = irq_mask;
    next_rdata     = 32'h0000_0000;
    // Software side: writes, clears on read
    if (wr_ctl && wdata_i[`TW_CTL_MSEN]) begin
      next_master_en = 1'b1;
    end
    // Disable touches no status flag [R4]
    if (master_disable_bit_wr) begin
      next_master_en = 1'b0;
    end
    if (wr_ctl && wdata_i[`TW_CTL_STOP]) begin
      next_stop_pend = 1'b1;
    end
    if (wr_i && hit(addr_i, `TW_OFF_MODE)) begin
      next_mode = {wdata_i[`TW_MODE_ADDR_HI:`TW_MODE_ADDR_LO], wdata_i[`TW_MODE_READ]};
    end
    if (wr_i && hit(addr_i, `TW_OFF_CLOCK)) begin
      next_clk_cfg = wdata_i[18:0];
    end
    if (wr_i && hit(addr_i, `TW_OFF_IRQ_MASK)) begin
      next_irq_mask = wdata_i[4:0];
    end
    if (wr_tx) begin
      next_tx_hold                   = wdata_i[7:0];
      next_flags.transmit_ready_flag = 1'b0;
    end
    if (rd_rx) begin
      next_flags.receive_ready_flag = 1'b0;
    end
    // Status read clears nack and overrun [R7]
    if (rd_stat) begin
      next_flags.nack_flag            = 1'b0;
      next_flags.receive_overrun_flag = 1'b0;
    end
    // Hardware side: sets win over the clears above
    if (ev_start) begin
      next_flags.transfer_complete_flag = 1'b0;
    end
    if (ev_take) begin
      next_flags.transmit_ready_flag = 1'b1;
    end
    // Completion and nack rise together [R7]
    if (ev_done) begin
      next_flags.transfer_complete_flag = 1'b1;
      next_flags.nack_flag              = next_flags.nack_flag || nack_pend;
      next_stop_pend                    = 1'b0;
    end
    // Transmit byte overwrites the holding register, no receive flag moves [R9] [R10]
    if (ev_wr_byte || ev_rd_byte) begin
      next_rx_hold = rxsh;
    end
    if (ev_rd_byte) begin
      next_flags.receive_ready_flag = 1'b1;
      // The byte after a stop request never reports the loss [R1]
      if (flags.receive_ready_flag && !rd_rx && !last) begin
        next_flags.receive_overrun_flag = 1'b1;
      end
    end
    // Sticky events: write one to clear, new rise wins
    if (wr_i && hit(addr_i, `TW_OFF_IRQ_STAT)) begin
      next_irq_stat = irq_stat & ~wdata_i[4:0];
    end
    next_irq_stat = next_irq_stat | (next_flags & ~flags);
    next_irq      = |(next_irq_stat & next_irq_mask);
    // Read data, shown in the cycle after the strobe only
    if (rd_i) begin
      case (addr_i)
        `TW_OFF_MODE:     next_rdata = {9'h000, mode.dev_addr, 3'h0, mode.read_dir, 12'h000};
        `TW_OFF_CLOCK:    next_rdata = {13'h0000, clk_cfg};
        `TW_OFF_STATUS:   next_rdata = {27'h000_0000, flags};
        `TW_OFF_IRQ_STAT: next_rdata = {27'h000_0000, irq_stat};
        `TW_OFF_IRQ_MASK: next_rdata = {27'h000_0000, irq_mask};
        `TW_OFF_RX_HOLD:  next_rdata = {24'h00_0000, receive_holding_reg};
        default:          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      master_en           <= 1'b0;
      stop_pend           <= 1'b0;
      mode                <= '0;
      clk_cfg             <= `TW_CLOCK_RST;
      tx_hold             <= 8'h00;
      receive_holding_reg <= 8'h00;
      flags               <= `TW_FLAGS_RST;
      irq_stat            <= '0;
      irq_mask            <= `TW_MASK_RST;
      rdata_o             <= 32'h0000_0000;
      irq_o               <= 1'b0;
    end else begin
      master_en           <= next_master_en;
      stop_pend           <= next_stop_pend;
      mode                <= next_mode;
      clk_cfg             <= next_clk_cfg;
      tx_hold             <= next_tx_hold;
      receive_holding_reg <= next_rx_hold;
      flags               <= next_flags;
      irq_stat            <= next_irq_stat;
      irq_mask            <= next_irq_mask;
      rdata_o             <= next_rdata;
      irq_o               <= next_irq;
    end
  end

  // Helper: running cycles spent in the current low phase
  logic [CNT_W-1:0] lo_cyc;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || state != tw_pkg::ST_LOW) begin
      lo_cyc <= '0;
    end else if (run && !tick) begin
      lo_cyc <= CNT_W'(lo_cyc + 1'b1);
    end
  end

  property p_nack_with_done;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(flags.nack_flag) |-> $rose(flags.transfer_complete_flag);
  endproperty
  a_nack_with_done: assert property (p_nack_with_done) else $error("nack rose alone"); // [R7]

  property p_nack_read_clear;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (rd_stat && !ev_done) |=> !flags.nack_flag;
  endproperty
  a_nack_read_clear: assert property (p_nack_read_clear) else $error("nack survived read"); // [R7]

  property p_nack_lost;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (rd_stat && nack_pend && state != tw_pkg::ST_IDLE && !ev_done) |=> !nack_pend ##0 !$rose(flags.nack_flag);
  endproperty
  a_nack_lost: assert property (p_nack_lost) else $error("nack kept after window read"); // [R6]

  property p_freeze;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    master_disable_bit_wr |=> ($stable(state) && $stable(scl_oe_o) && $stable(bitcnt));
  endproperty
  a_freeze: assert property (p_freeze) else $error("engine moved after disable"); // [R3]

  property p_disable_flags;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (master_disable_bit_wr && !wr_tx) |=> ($stable(flags.transfer_complete_flag) && $stable(flags.transmit_ready_flag));
  endproperty
  a_disable_flags: assert property (p_disable_flags) else $error("disable changed flags"); // [R4]

  property p_tx_corrupts;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ev_wr_byte |=> (receive_holding_reg == $past(rxsh)) && !$rose(flags.receive_ready_flag);
  endproperty
  a_tx_corrupts: assert property (p_tx_corrupts) else $error("holding register not overwritten"); // [R9]

  property p_tx_no_flags;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ev_wr_byte && !rd_rx) |=> !$rose(flags.receive_overrun_flag) && !$rose(irq_stat.receive_ready_flag);
  endproperty
  a_tx_no_flags: assert property (p_tx_no_flags) else $error("flag raised on tx overwrite"); // [R10]

  property p_last_no_overrun;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ev_rd_byte && last) |=> !$rose(flags.receive_overrun_flag);
  endproperty
  a_last_no_overrun: assert property (p_last_no_overrun) else $error("overrun on last byte"); // [R1]

  property p_overrun_normal;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ev_rd_byte && !last && flags.receive_ready_flag && !rd_rx) |=> flags.receive_overrun_flag;
  endproperty
  a_overrun_normal: assert property (p_overrun_normal) else $error("overrun missed"); // [R1]

  property p_low_len;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (state == tw_pkg::ST_LOW && tick) |-> (lo_cyc == CNT_W'(len_low - 1'b1));
  endproperty
  a_low_len: assert property (p_low_len) else $error("low phase length wrong"); // [R12]

  c_write_done: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) ev_done && !mode.read_dir);
  c_read_done: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) ev_done && mode.read_dir);
  c_nack: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) $rose(flags.nack_flag));
  c_freeze: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) master_disable_bit_wr && state != tw_pkg::ST_IDLE);
endmodule
`default_nettype wire

// File: bench/tw_slave_model.sv
// Purpose: Behavioural slave on the two-wire bus
// Assumes: Wires resolved in the bench with pull-ups
// Notes:   Acks address and written bytes while ack_en_i is high
`timescale 1ns/1ps
`default_nettype none
module tw_slave_model (
  input  wire logic       scl_i,     // Resolved clock wire
  input  wire logic       sda_i,     // Resolved data wire
  input  wire logic       ack_en_i,  // Low answers every byte with a nack
  input  wire logic [7:0] rd_byte_i, // Byte returned on reads
  output logic            pull_o     // High pulls data low
);
  int   k;       // Clock rises since start
  logic rd_mode; // Direction bit of the address
  logic done;    // Master nacked, keep off the wire
  initial begin
    k = 0;
    rd_mode = 0;
    done = 0;
    pull_o = 0;
  end
  // Data edge while clock high is a start or stop
  always @(sda_i) if (scl_i) begin
    k = 0;
    rd_mode = 0;
    done = 0;
    pull_o = 0;
  end
  // Direction from eighth bit; master nack ends reading
  always @(posedge scl_i) begin
    if (k == 7) rd_mode = sda_i;
    if (rd_mode && k > 8 && k % 9 == 8 && sda_i) done = 1;
    k++;
  end
  // Next slot driven only after the clock falls, so data never moves while high
  always @(negedge scl_i)
    if (k % 9 == 8) pull_o = ack_en_i && (k < 9 || !rd_mode);
    else pull_o = rd_mode && k > 8 && !done && !rd_byte_i[7 - k % 9];
endmodule
`default_nettype wire

// File: bench/two_wire_master_quirks_bench.sv
// Purpose: Self-checking bench of the two-wire master
// Assumes: Slave model on the far side, pull-ups on both wires
// Notes:   Dividers of 7 plus the sync stall give a 160 ns link clock
`timescale 1ns/1ps
`default_nettype none
`include "tw_defines.svh"
module two_wire_master_quirks_bench;
  logic        clk_sys_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, ack_en = 1, sp = 1;
  logic [7:0]  addr_i = 0, rx_byte = 0, tx_byte = 0;
  logic [31:0] wdata_i = 0, rdata_o;
  logic        irq_o, scl_o, scl_oe_o, sda_o, sda_oe_o, pull;
  logic [1:0]  oe_held;                       // Pin enables at freeze
  int          fail_count = 0, checks_done = 0, seed = 32'h7f52, n;
  wire         scl_w = !scl_oe_o;             // Pull-up wire levels
  wire         sda_w = !sda_oe_o && !pull;
  tw_master #(.CNT_W(13)) i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
  tw_slave_model i_slave (.scl_i(scl_w), .sda_i(sda_w), .ack_en_i(ack_en), .rd_byte_i(rx_byte), .pull_o(pull));
  always #5 clk_sys_i = ~clk_sys_i;
  // Verdict and end of run
  task automatic summarize();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Gap cycle after each strobe keeps one assignment per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
    @(posedge clk_sys_i);
  endtask
  // Bounded waits; running out ends the run as failed
  task automatic wait_irq();
    for (n = 0; n < 3000 && irq_o !== 1'b1; n++) @(posedge clk_sys_i);
    if (irq_o !== 1'b1) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic wait_rises(input int cnt);
    n = 0;
    for (int i = 0; i < 3000 && n < cnt; i++) begin
      @(posedge clk_sys_i);
      if (scl_w && !sp) n++;
      sp = scl_w;
    end
    if (n < cnt) begin
      fail_count++;
      summarize();
    end
  endtask
  // Clear events, random slave address, then start
  task automatic frame(input logic dir);
    wr(`TW_OFF_IRQ_STAT, 32'h0000_001F);
    wr(`TW_OFF_MODE, {9'h000, 7'($random(seed)), 3'h0, dir, 12'h000});
    wr(`TW_OFF_CONTROL, 32'h0000_0001);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(`TW_OFF_STATUS, 32'h0000_0005);
    rd(8'h3C, 32'h0000_0000);
    wr(`TW_OFF_CLOCK, 32'h0000_0707);
    wr(`TW_OFF_IRQ_MASK, 32'h0000_0001);
    wr(`TW_OFF_CONTROL, 32'h0000_0004);
    tx_byte = 8'($random(seed));
    rx_byte = 8'($random(seed));
    // Acked write: bus byte lands in receive holding silently
    wr(`TW_OFF_TX_HOLD, {24'h00_0000, tx_byte});
    frame(1'b0);
    wait_irq();
    rd(`TW_OFF_STATUS, 32'h0000_0005);
    rd(`TW_OFF_RX_HOLD, {24'h00_0000, tx_byte});
    wr(`TW_OFF_IRQ_MASK, 32'h0000_0000);
    #1 chk(irq_o, 1'b0);
    wr(`TW_OFF_IRQ_MASK, 32'h0000_0001);
    #1 chk(irq_o, 1'b1);
    // Nacked address: nack with completion, cleared by one read
    ack_en = 1'b0;
    frame(1'b0);
    wait_irq();
    rd(`TW_OFF_STATUS, 32'h0000_000D);
    rd(`TW_OFF_STATUS, 32'h0000_0005);
    ack_en = 1'b1;
    // Read, stop mid byte one: first byte overwritten by second, no overrun
    frame(1'b1);
    wait_rises(13);
    wr(`TW_OFF_CONTROL, 32'h0000_0002);
    wait_irq();
    rd(`TW_OFF_STATUS, 32'h0000_0007);
    rd(`TW_OFF_RX_HOLD, {24'h00_0000, rx_byte});
    // Status read after nack, before completion: nack lost
    ack_en = 1'b0;
    frame(1'b0);
    wait_rises(9);
    repeat (12) @(posedge clk_sys_i);
    rd(`TW_OFF_STATUS, 32'h0000_0004);
    wait_irq();
    rd(`TW_OFF_STATUS, 32'h0000_0005);
    ack_en = 1'b1;
    // Disable mid address byte freezes pins; transmit ready stays set
    wr(`TW_OFF_IRQ_MASK, 32'h0000_0000);
    frame(1'b0);
    wait_rises(3);
    wr(`TW_OFF_CONTROL, 32'h0000_0008);
    oe_held = {scl_oe_o, sda_oe_o};
    repeat (40) @(posedge clk_sys_i);
    chk({30'h0, scl_oe_o, sda_oe_o}, {30'h0, oe_held});
    rd(`TW_OFF_STATUS, 32'h0000_0004);
    rst_n_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(`TW_OFF_STATUS, 32'h0000_0005);
    chk({31'h0, irq_o}, 32'h0000_0000);
    chk({30'h0, scl_o, sda_o}, 32'h0000_0000);
    summarize();
  end
endmodule
`default_nettype wire
